/* File: cbt_map.vh */
// cbt_map.vh: register map, field layout, reset values and timing constants of the bit timing block
// assumes a 25 MHz system clock and a 32-bit AHB-Lite register bus
`ifndef CBT_MAP_VH
`define CBT_MAP_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CBT_ADDR_CTRL     4'h0
`define CBT_ADDR_TIMING   4'h4
`define CBT_ADDR_STATUS   4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CBT_CTRL_EN       0
`define CBT_TIM_BRP_LO    0
`define CBT_TIM_BRP_HI    5
`define CBT_TIM_SEG1_LO   8
`define CBT_TIM_SEG1_HI   12
`define CBT_TIM_SEG2_LO   16
`define CBT_TIM_SEG2_HI   19
`define CBT_TIM_SJW_LO    24
`define CBT_TIM_SJW_HI    27
`define CBT_ST_RXBIT      0
`define CBT_ST_NQ_OK      1
`define CBT_ST_RATE_OK    2
`define CBT_ST_PROP_OK    3
`define CBT_ST_JUMP_OK    4
`define CBT_ST_CNT_LO     16

// ----------------------------------------------------------------
// reset values: 5 clocks per quantum, 1 + 7 + 2 = 10 quanta, jump of 2
// ----------------------------------------------------------------
`define CBT_RST_BRP       6'h05
`define CBT_RST_SEG1      5'h07
`define CBT_RST_SEG2      4'h2
`define CBT_RST_SJW       4'h2

// ----------------------------------------------------------------
// timing figures in ns, quanta-per-bit limits and derived clock counts
// ----------------------------------------------------------------
`define CBT_CLK_NS        40
`define CBT_BIT_NOM_NS    2000
`define CBT_BIT_MIN_NS    1990
`define CBT_BIT_MAX_NS    2010
`define CBT_TQ_MAX_NS     200
`define CBT_BUS_MAX_NS    198
`define CBT_ECU_MAX_NS    390
`define CBT_NQ_MIN        10
`define CBT_NQ_MAX        22
`define CBT_BIT_MIN_CYC   ((`CBT_BIT_MIN_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)
`define CBT_BIT_MAX_CYC   (`CBT_BIT_MAX_NS / `CBT_CLK_NS)
`define CBT_TQ_MAX_CYC    (`CBT_TQ_MAX_NS / `CBT_CLK_NS)
`define CBT_PROP_NS       (2 * (`CBT_ECU_MAX_NS + `CBT_BUS_MAX_NS))
`define CBT_PROP_CYC      ((`CBT_PROP_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)

`endif

/* File: cbt_bit_timing.v */
// cbt_bit_timing.v: quantum divider, bit segment sequencer, resync and sampling, with an AHB-Lite register slave
// assumes rx_in is synchronous to clock, 1 = recessive, and a single AHB-Lite master
`include "cbt_map.vh"
`timescale 1ns/1ps
`default_nettype none

module cbt_bit_timing
(
    input  wire        clock,        // 25 MHz system clock
    input  wire        rst_b,        // async reset, active low
    input  wire        hsel,         // slave select
    input  wire [31:0] haddr,        // byte address
    input  wire [1:0]  htrans,       // transfer type
    input  wire        hwrite,       // write when high
    input  wire [2:0]  hsize,        // word only
    input  wire [31:0] hwdata,       // write data
    input  wire        hready,       // bus ready
    output reg         hreadyout,    // slave ready
    output reg  [31:0] hrdata,       // read data
    output reg         hresp,        // always okay
    input  wire        rx_in,        // bus level from transceiver
    output reg         rx_bit,       // last sampled bit
    output reg         sample_stb,   // one-cycle pulse at sample point
    output reg         bit_start     // one-cycle pulse at bit start
);

// ----------------------------------------------------------------
// reset release and helpers
// ----------------------------------------------------------------
localparam ST_SYNC = 2'b00;
localparam ST_SEG1 = 2'b01;
localparam ST_SEG2 = 2'b10;

// the released reset reaches the logic two clocks late, so the bus must wait for it
reg         rst_s1_q;
reg         rst_b_q;

always @(posedge clock or negedge rst_b)
begin
    if (!rst_b)
    begin
        rst_s1_q <= 1'b0;
        rst_b_q  <= 1'b0;
    end
    else
    begin
        rst_s1_q <= 1'b1;
        rst_b_q  <= rst_s1_q;
    end
end

// total quanta in one bit; the sync quantum is always one and is not programmable
function [5:0] nq_of;
    input [4:0] s1;
    input [3:0] s2;
    begin
        nq_of = 6'h01 + {1'b0, s1} + {2'h0, s2};
    end
endfunction

// smaller of two jump amounts
// a late edge is only corrected by what has elapsed, never past the jump limit
function [3:0] min4;
    input [4:0] a;
    input [3:0] b;
    begin
        min4 = (a < {1'b0, b}) ? a[3:0] : b;
    end
endfunction

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
reg         en_q;
reg  [5:0]  brp_q;
reg  [4:0]  seg1_q;
reg  [3:0]  seg2_q;
reg  [3:0]  sjw_q;
reg  [15:0] bit_cnt_q;

reg         pend_q;
reg         pend_wr_q;
reg  [3:0]  pend_addr_q;

// hsize is not decoded: only whole-word transfers are expected on this bus
wire        take = hsel & htrans[1] & hready;
wire [5:0]  nq_sw = nq_of(seg1_q, seg2_q);
wire [11:0] bit_clk_sw = brp_q * nq_sw;
wire [10:0] pre_clk_sw = brp_q * seg1_q;

// configuration checks shown in status
wire        nq_ok = (nq_sw >= `CBT_NQ_MIN) && (nq_sw <= `CBT_NQ_MAX)
                    && (brp_q <= `CBT_TQ_MAX_CYC) && (brp_q != 6'h00);
wire        rate_ok = (bit_clk_sw >= `CBT_BIT_MIN_CYC) && (bit_clk_sw <= `CBT_BIT_MAX_CYC);
wire        prop_ok = (pre_clk_sw >= `CBT_PROP_CYC);
wire        jump_ok = (sjw_q != 4'h0) && (sjw_q <= seg2_q);

reg  [31:0] rd_val;

always @*
begin
    rd_val = 32'h0000_0000;
    case (pend_addr_q)
        `CBT_ADDR_CTRL:
            rd_val[`CBT_CTRL_EN] = en_q;
        `CBT_ADDR_TIMING:
        begin
            rd_val[`CBT_TIM_BRP_HI:`CBT_TIM_BRP_LO]   = brp_q;
            rd_val[`CBT_TIM_SEG1_HI:`CBT_TIM_SEG1_LO] = seg1_q;
            rd_val[`CBT_TIM_SEG2_HI:`CBT_TIM_SEG2_LO] = seg2_q;
            rd_val[`CBT_TIM_SJW_HI:`CBT_TIM_SJW_LO]   = sjw_q;
        end
        `CBT_ADDR_STATUS:
        begin
            rd_val[`CBT_ST_RXBIT]   = rx_bit;
            rd_val[`CBT_ST_NQ_OK]   = nq_ok;
            rd_val[`CBT_ST_RATE_OK] = rate_ok;
            rd_val[`CBT_ST_PROP_OK] = prop_ok;
            rd_val[`CBT_ST_JUMP_OK] = jump_ok;
            rd_val[31:`CBT_ST_CNT_LO] = bit_cnt_q;
        end
        default:
            rd_val = 32'h0000_0000;
    endcase
end

// every transfer gets one wait state so a read always follows a finished write
always @(posedge clock or negedge rst_b_q)
begin
    if (!rst_b_q)
    begin
        pend_q      <= 1'b0;
        pend_wr_q   <= 1'b0;
        pend_addr_q <= 4'h0;
        hreadyout   <= 1'b1;
        hrdata      <= 32'h0000_0000;
        hresp       <= 1'b0;
        en_q        <= 1'b1;
        brp_q       <= `CBT_RST_BRP;
        seg1_q      <= `CBT_RST_SEG1;
        seg2_q      <= `CBT_RST_SEG2;
        sjw_q       <= `CBT_RST_SJW;
    end
    else if (pend_q)
    begin
        pend_q    <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= pend_wr_q ? 32'h0000_0000 : rd_val;
        if (pend_wr_q && pend_addr_q == `CBT_ADDR_CTRL)
            en_q <= hwdata[`CBT_CTRL_EN];
        if (pend_wr_q && pend_addr_q == `CBT_ADDR_TIMING)
        begin
            brp_q  <= hwdata[`CBT_TIM_BRP_HI:`CBT_TIM_BRP_LO];
            seg1_q <= hwdata[`CBT_TIM_SEG1_HI:`CBT_TIM_SEG1_LO];
            seg2_q <= hwdata[`CBT_TIM_SEG2_HI:`CBT_TIM_SEG2_LO];
            sjw_q  <= hwdata[`CBT_TIM_SJW_HI:`CBT_TIM_SJW_LO];
        end
    end
    else if (take)
    begin
        pend_q      <= 1'b1;
        pend_wr_q   <= hwrite;
        pend_addr_q <= (haddr[31:4] == 28'h0) ? haddr[3:0] : 4'hc;
        hreadyout   <= 1'b0;
    end
end

// ----------------------------------------------------------------
// active settings, reloaded at bit boundaries and while disabled
// ----------------------------------------------------------------
reg  [5:0]  a_brp_q;
reg  [4:0]  a_seg1_q;
reg  [3:0]  a_seg2_q;
reg  [3:0]  a_sjw_q;

reg  [5:0]  presc_q;
reg  [1:0]  state_q;
reg  [4:0]  tq_cnt_q;
reg  [3:0]  ext_q;
reg  [3:0]  cut_q;
reg         synced_q;
reg         rx_last_q;

// a zero prescaler would stall the divider, so it is treated as one
// the divider restarts at each bit so a resync never leaves a partial quantum behind
wire [5:0]  brp_eff = (a_brp_q == 6'h00) ? 6'h01 : a_brp_q;
wire        tq_en = en_q && (presc_q == brp_eff - 6'h01);
wire        edge_fall = rx_last_q & ~rx_in;
wire        resync = en_q && edge_fall && !synced_q;
wire [4:0]  seg1_end = a_seg1_q + {1'b0, ext_q} - 5'h01;
wire [4:0]  seg2_left = {1'b0, a_seg2_q} - tq_cnt_q;
wire [4:0]  seg2_end = {1'b0, a_seg2_q} - {1'b0, cut_q} - 5'h01;

// ----------------------------------------------------------------
// quantum divider and segment sequencer
// ----------------------------------------------------------------
always @(posedge clock or negedge rst_b_q)
begin
    if (!rst_b_q)
    begin
        a_brp_q    <= `CBT_RST_BRP;
        a_seg1_q   <= `CBT_RST_SEG1;
        a_seg2_q   <= `CBT_RST_SEG2;
        a_sjw_q    <= `CBT_RST_SJW;
        presc_q    <= 6'h00;
        state_q    <= ST_SYNC;
        tq_cnt_q   <= 5'h00;
        ext_q      <= 4'h0;
        cut_q      <= 4'h0;
        synced_q   <= 1'b0;
        rx_last_q  <= 1'b1;
        rx_bit     <= 1'b1;
        sample_stb <= 1'b0;
        bit_start  <= 1'b0;
        bit_cnt_q  <= 16'h0000;
    end
    else
    begin
        rx_last_q  <= rx_in;
        sample_stb <= 1'b0;
        bit_start  <= 1'b0;
        if (!en_q)
        begin
            // held idle: settings follow software freely
            presc_q  <= 6'h00;
            state_q  <= ST_SYNC;
            tq_cnt_q <= 5'h00;
            ext_q    <= 4'h0;
            cut_q    <= 4'h0;
            synced_q <= 1'b0;
            a_brp_q  <= brp_q;
            a_seg1_q <= seg1_q;
            a_seg2_q <= seg2_q;
            a_sjw_q  <= sjw_q;
        end
        else
        begin
            presc_q <= tq_en ? 6'h00 : presc_q + 6'h01;
            case (state_q)
                ST_SYNC:
                begin
                    if (edge_fall)
                        synced_q <= 1'b1;
                    if (tq_en)
                    begin
                        state_q  <= ST_SEG1;
                        tq_cnt_q <= 5'h00;
                    end
                end
                ST_SEG1:
                begin
                    if (resync)
                    begin
                        ext_q    <= min4(tq_cnt_q + 5'h01, a_sjw_q);
                        synced_q <= 1'b1;
                    end
                    if (tq_en)
                    begin
                        if (tq_cnt_q >= seg1_end)
                        begin
                            rx_bit     <= rx_in;
                            sample_stb <= 1'b1;
                            state_q    <= ST_SEG2;
                            tq_cnt_q   <= 5'h00;
                        end
                        else
                            tq_cnt_q <= tq_cnt_q + 5'h01;
                    end
                end
                ST_SEG2:
                begin
                    if (resync && seg2_left <= {1'b0, a_sjw_q})
                    begin
                        // edge close enough to the end: it opens the next bit
                        state_q  <= ST_SYNC;
                        presc_q  <= 6'h00;
                        synced_q <= 1'b1;
                    end
                    else
                    begin
                        if (resync)
                        begin
                            cut_q    <= a_sjw_q;
                            synced_q <= 1'b1;
                        end
                        if (tq_en && (tq_cnt_q >= seg2_end || cut_q >= a_seg2_q))
                            state_q <= ST_SYNC;
                        else if (tq_en)
                            tq_cnt_q <= tq_cnt_q + 5'h01;
                    end
                end
                default:
                    state_q <= ST_SYNC;
            endcase
            // bit boundary: reload settings, clear corrections
            // this test must cover every exit from the post-sample segment in the case above,
            // otherwise a bit ends without its pulse and keeps stale settings and corrections
            // an edge far from the end may shorten the bit, but its cut only ends it at a later tq_en, never in the same cycle
            if (state_q == ST_SEG2 && (
                (resync && seg2_left <= {1'b0, a_sjw_q}) ||
                (tq_en && (tq_cnt_q >= seg2_end || cut_q >= a_seg2_q))))
            begin
                a_brp_q   <= brp_q;
                a_seg1_q  <= seg1_q;
                a_seg2_q  <= seg2_q;
                a_sjw_q   <= sjw_q;
                ext_q     <= 4'h0;
                cut_q     <= 4'h0;
                tq_cnt_q  <= 5'h00;
                bit_start <= 1'b1;
                bit_cnt_q <= bit_cnt_q + 16'h0001;
                if (!(resync && seg2_left <= {1'b0, a_sjw_q}))
                    synced_q <= 1'b0;
            end
        end
    end
end

endmodule // cbt_bit_timing

`default_nettype wire

/* File: cbt_bit_timing_monitor.sv */
// cbt_bit_timing_monitor.sv: port assertions of the bit timing block
// assumes default timing until software writes ctrl or timing
`include "cbt_map.vh"
`timescale 1ns/1ps
`default_nettype none
module cbt_bit_timing_monitor (
    input wire logic        clock,      // clock
    input wire logic        rst_b,      // reset
    input wire logic        hsel,       // select
    input wire logic [31:0] haddr,      // address
    input wire logic [1:0]  htrans,     // type
    input wire logic        hwrite,     // write
    input wire logic [2:0]  hsize,      // size
    input wire logic [31:0] hwdata,     // wdata
    input wire logic        hready,     // ready in
    input wire logic        hreadyout,  // ready out
    input wire logic [31:0] hrdata,     // rdata
    input wire logic        hresp,      // response
    input wire logic        rx_in,      // bus level
    input wire logic        rx_bit,     // sampled bit
    input wire logic        sample_stb, // sample pulse
    input wire logic        bit_start   // bit pulse
);
    localparam int BIT_C = `CBT_BIT_NOM_NS / `CBT_CLK_NS;
    localparam int SMP_C = `CBT_RST_BRP * (`CBT_RST_SEG1 + 1);
    // --------
    // helper logic
    // --------
    logic [7:0] cnt_q;
    logic [1:0] ns_q;
    logic       rx_q, ec_q, ep_q, dflt_q;
    wire        take  = hsel & htrans[1] & hready;
    wire        fall  = rx_q & ~rx_in;
    // a bit is only timed exactly when no edge could have moved it
    wire        clean = dflt_q & ~ec_q & ~ep_q & ~fall;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {cnt_q, ns_q} <= '0;
            {rx_q, ec_q, ep_q, dflt_q} <= 4'hf;
        end
        else
        begin
            rx_q  <= rx_in;
            cnt_q <= bit_start ? 8'h00 : cnt_q + 8'h01;
            ns_q  <= bit_start ? 2'h0 : ns_q + {1'b0, sample_stb & ~ns_q[1]};
            ec_q  <= bit_start ? fall : ec_q | fall;
            ep_q  <= bit_start ? ec_q | fall : ep_q;
            if (take && hwrite && haddr[31:3] == 29'h0)
                dflt_q <= 1'b0;
        end
    end
    // --------
    // assertions
    // --------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    okay_resp_a: assert property (hresp == 1'b0) else $error("error response");
    wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout) else $error("bad wait state");
    write_zero_a: assert property (take && hwrite |-> ##2 hrdata == 32'h0) else $error("rdata after write");
    sample_pulse_a: assert property (sample_stb |=> !sample_stb) else $error("long sample");
    one_sample_a: assert property (bit_start |-> ns_q <= 2'h1) else $error("two samples");
    rx_hold_a: assert property ($changed(rx_bit) |-> sample_stb) else $error("rx_bit moved");
    rx_latch_a: assert property (sample_stb && $past(rx_in, 2) == $past(rx_in)
        |-> rx_bit == $past(rx_in)) else $error("wrong sample");
    bit_len_a: assert property (bit_start && clean |-> cnt_q == BIT_C - 1) else $error("bit length");
    sample_pos_a: assert property (sample_stb && clean |-> cnt_q == SMP_C - 1) else $error("sample point");
    cover property (bit_start && clean);
    cover property (take && hwrite);
    cover property (sample_stb && !rx_bit);
endmodule // cbt_bit_timing_monitor
bind cbt_bit_timing cbt_bit_timing_monitor mon (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rx_in(rx_in), .rx_bit(rx_bit), .sample_stb(sample_stb),
    .bit_start(bit_start));
`default_nettype wire

/* File: cbt_bus_node.sv */
// cbt_bus_node.sv: another node as the receiver sees it through the transceiver
// assumes the bench calls drive right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module cbt_bus_node (
    input  wire logic clock, // clock
    output var  logic rx_in  // 1 = recessive
);
    // --------
    // bus level
    // --------
    // idle bus is recessive through the termination
    initial rx_in = 1'b1;
    // the node shares the 2000 ns bit; the bench sets each level for a whole bit
    task automatic drive(input logic lvl);
        rx_in <= lvl;
    endtask
endmodule // cbt_bus_node
`default_nettype wire

/* File: tb_can_bit_timing_500k.sv */
// tb_can_bit_timing_500k.sv: self-checking bench of the bit timing block
// assumes the design, its monitor and the bus node model are compiled first
`include "cbt_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_can_bit_timing_500k;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] seed = 32'd91642;
    logic [31:0] q;
    wire         hreadyout, hresp, rx_in, rx_bit, sample_stb, bit_start;
    wire  [31:0] hrdata;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          off[3] = '{0, 21, 44};
    int          lo[3] = '{50, 60, 45};
    int          hi[3] = '{50, 60, 49};
    localparam logic [31:0] A_CTL = {28'h0, `CBT_ADDR_CTRL};
    localparam logic [31:0] A_TIM = {28'h0, `CBT_ADDR_TIMING};
    localparam logic [31:0] A_ST = {28'h0, `CBT_ADDR_STATUS};
    always #20 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    cbt_bit_timing dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .rx_in(rx_in), .rx_bit(rx_bit), .sample_stb(sample_stb),
        .bit_start(bit_start));
    cbt_bus_node node (.clock(clock), .rx_in(rx_in));
    // --------
    // helpers
    // --------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] tim(int p, int a, int b, int j);
        return {4'h0, 4'(j), 4'h0, 4'(b), 3'h0, 5'(a), 2'h0, 6'(p)};
    endfunction
    function automatic logic [31:0] stx(int p, int a, int b, int j, logic rb);
        int nq;
        nq = 1 + a + b;
        return {27'h0, j >= 1 && j <= b, p * a >= `CBT_PROP_CYC, p * nq * `CBT_CLK_NS == `CBT_BIT_NOM_NS,
            nq >= `CBT_NQ_MIN && nq <= `CBT_NQ_MAX && p >= 1 && p * `CBT_CLK_NS <= `CBT_TQ_MAX_NS, rb};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic hang(input int n);
        if (n >= 400)
        begin
            miscompares++;
            finish_test();
        end
    endtask
    task automatic wait_ev(input logic smp);
        int n;
        n = 0;
        do @(posedge clock); while ((smp ? sample_stb : bit_start) !== 1'b1 && ++n < 400);
        hang(n);
    endtask
    // one whole-word transfer; the slave sets the pace
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 400);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 400);
        q = hrdata;
        hang(n);
    endtask
    // --------
    // main sequence
    // --------
    initial
    begin
        int t;
        int g;
        logic b;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        bus(1'b0, A_CTL, 32'h0);
        chk(q, 32'h1);
        bus(1'b0, A_TIM, 32'h0);
        chk(q, tim(5, 7, 2, 2));
        bus(1'b0, A_ST, 32'h0);
        chk(q & 32'h1f, stx(5, 7, 2, 2, 1'b1));
        bus(1'b1, 32'h10, 32'hffffffff);
        bus(1'b0, 32'h10, 32'h0);
        chk(q, 32'h0);
        $display("registers done");
        // random bits, the other node sometimes one clock slow
        wait_ev(1'b0);
        repeat (30)
        begin
            b = 1'(rnd());
            g = 50 + int'(rnd() % 2);
            t = cyc;
            node.drive(b);
            wait_ev(1'b1);
            chk(rx_bit, b);
            while (cyc - t < g) @(posedge clock);
        end
        $display("random bits done");
        foreach (off[i])
        begin
            node.drive(1'b1);
            wait_ev(1'b0);
            wait_ev(1'b0);
            repeat (off[i]) @(posedge clock);
            t = cyc - off[i];
            node.drive(1'b0);
            wait_ev(1'b0);
            chk(cyc - t >= lo[i] && cyc - t <= hi[i], 32'h1);
        end
        $display("resync done");
        // new settings written mid-bit must wait for the boundary
        node.drive(1'b1);
        wait_ev(1'b1);
        t = cyc;
        bus(1'b1, A_TIM, tim(4, 13, 4, 4));
        wait_ev(1'b0);
        chk(cyc - t, 32'd10);
        t = cyc;
        wait_ev(1'b1);
        chk(cyc - t, 32'd56);
        wait_ev(1'b0);
        chk(cyc - t, 32'd72);
        bus(1'b0, A_ST, 32'h0);
        chk(q & 32'h1f, stx(4, 13, 4, 4, 1'b1));
        bus(1'b1, A_CTL, 32'h0);
        repeat (2) @(posedge clock);
        t = 0;
        repeat (100)
        begin
            @(posedge clock);
            t += int'(bit_start !== 1'b0);
        end
        chk(t, 32'h0);
        bus(1'b1, A_TIM, tim(5, 7, 2, 2));
        bus(1'b1, A_CTL, 32'h1);
        wait_ev(1'b0);
        t = cyc;
        wait_ev(1'b0);
        chk(cyc - t, 32'd50);
        $display("reconfigure done");
        finish_test();
    end
endmodule // tb_can_bit_timing_500k
`default_nettype wire
